// file: bench/adcpp_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host processor model
// ****************************************
module adcpp_host (
  // clock
  input  wire logic        SYS_CLK,
  // conversion control
  output logic             CONVERT_START_N,
  output logic             CONVERSION_CLOCK_IN,
  input  wire logic        BUSY,
  // parallel bus
  output logic             CS_N,
  output logic             RD_N,
  output logic             WR_N,
  output logic             WORD_BYTE_SELECT,
  output logic [11:0]      DATA_IN,
  input  wire logic [11:0] DATA_OUT,
  input  wire logic        DATA_OE
);
  int tmo_cnt;                         // overrun waits
  // free conversion clock, 8 system cycles a period
  initial begin
    CONVERSION_CLOCK_IN = 1'b0;
    forever #160 CONVERSION_CLOCK_IN = ~CONVERSION_CLOCK_IN;
  end
  // strobe idles low so power-down lasts
  initial begin
    {CONVERT_START_N, CS_N, RD_N, WR_N, WORD_BYTE_SELECT} = 5'h0f;
    DATA_IN = 12'h000;
    tmo_cnt = 0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  // one write; data held past strobe rise, then lines change
  task automatic wr(input logic wbs, input logic [11:0] d);
    WORD_BYTE_SELECT = wbs;
    DATA_IN = d;
    {CS_N, WR_N} = 2'h0;
    step(4);
    {CS_N, WR_N} = 2'h3;
    step(5);
    DATA_IN = ~d;
  endtask
  // one read, only while idle so linearity is kept
  task automatic rd(input logic wbs, input logic hbs, output logic [11:0] got);
    WORD_BYTE_SELECT = wbs;
    DATA_IN[8] = hbs;
    {CS_N, RD_N} = 2'h0;
    step(4);
    got = DATA_OE ? DATA_OUT : 12'hxxx;
    {CS_N, RD_N} = 2'h3;
    step(4);
  endtask
  // rise strobe only: wake or enter track
  task automatic rise();
    CONVERT_START_N = 1'b1;
  endtask
  // rise, acquire, start; optional permanent read; wait end
  task automatic conv(input logic keep, input int acq, output logic [11:0] last);
    int n;
    last = 12'hxxx;
    CONVERT_START_N = 1'b1;
    step(acq);
    {CS_N, RD_N} = {2{~keep}};
    CONVERT_START_N = 1'b0;
    n = 0;
    while (BUSY !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    n = 0;
    while (BUSY !== 1'b0 && n < 250) begin
      last = DATA_OE ? DATA_OUT : 12'hxxx;
      step(1);
      n++;
    end
    if (n >= 250) tmo_cnt++;
    {CS_N, RD_N} = 2'h3;
    step(3);
  endtask
  // early rise well before the 14th conversion-clock fall
  task automatic abort();
    CONVERT_START_N = 1'b1;
    step(4);
    CONVERT_START_N = 1'b0;
    step(24);
    CONVERT_START_N = 1'b1;
  endtask
endmodule // adcpp_host
`default_nettype wire

// file: bench/adcpp_port_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module adcpp_chk #(
  parameter DW = 12                    // data port width
) (
  // clock and reset
  input wire logic          SYS_CLK,
  input wire logic          RST_B,
  // bus strobes
  input wire logic          CS_N,
  input wire logic          RD_N,
  input wire logic          WR_N,
  // device outputs
  input wire logic          BUSY,
  input wire logic          DATA_OE,
  input wire logic          TRACK,
  input wire logic          CORE_POWERED,
  input wire logic          POWER_UP_START,
  input wire logic [DW-1:0] CONTROL_WORD
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic [3:0] since_wr_r;              // cycles since select and write low
  // saturating count; bounds how late a write may land
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      since_wr_r <= 4'hf;
    end else if (!CS_N && !WR_N) begin
      since_wr_r <= 4'h0;
    end else if (since_wr_r != 4'hf) begin
      since_wr_r <= since_wr_r + 4'h1;
    end
  end
  a_oe_follows_read: assert property ((!CS_N && !RD_N) [*4] |-> DATA_OE)
    else $error("bus not driven during read");
  a_oe_releases: assert property (CS_N [*4] |-> !DATA_OE)
    else $error("bus driven without select");
  a_start_holds: assert property ($rose(BUSY) |-> !TRACK && CORE_POWERED)
    else $error("conversion began without hold or power");
  a_busy_bounded: assert property ($rose(BUSY) |-> ##[1:200] !BUSY)
    else $error("busy never fell");
  a_end_tracks: assert property ($fell(BUSY) && CORE_POWERED |-> TRACK)
    else $error("not tracking after conversion");
  a_wake_pulse: assert property (POWER_UP_START |-> TRACK ##1 !POWER_UP_START)
    else $error("wake pulse wrong");
  a_fullsd_down: assert property (CONTROL_WORD[5:4] == 2'h3 |-> !CORE_POWERED && !TRACK)
    else $error("full shutdown not applied");
  a_write_capture: assert property (!$stable(CONTROL_WORD) |-> since_wr_r <= 4'h8)
    else $error("control word changed without write");
  c_conv_done: cover property ($fell(BUSY));
  c_wake: cover property (POWER_UP_START);
  c_fullsd: cover property (CONTROL_WORD[5:4] == 2'h3);
endmodule // adcpp_chk

bind adcpp_port adcpp_chk #(.DW(DW)) i_adcpp_chk (.SYS_CLK, .RST_B, .CS_N, .RD_N, .WR_N,
  .BUSY, .DATA_OE, .TRACK, .CORE_POWERED, .POWER_UP_START, .CONTROL_WORD);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // stand-in for the 10 ms wake wait, which the run cannot afford
  localparam int WAKE_CYC = 60;
  logic SYS_CLK, RST_B, CONVERT_START_N, CONVERSION_CLOCK_IN, CS_N, RD_N, WR_N;
  logic WORD_BYTE_SELECT, BUSY, DATA_OE, TRACK, CORE_POWERED, REF_POWERED, POWER_UP_START;
  logic [11:0] DATA_IN, DATA_OUT, SAR_RESULT, CONTROL_WORD, v;
  logic [1:0]  SAR_CHANNEL;
  int          error_cnt, compares, n;
  adcpp_port i_adcpp_port (.SYS_CLK, .RST_B, .CONVERT_START_N, .CONVERSION_CLOCK_IN, .BUSY,
    .CS_N, .RD_N, .WR_N, .WORD_BYTE_SELECT, .DATA_IN, .DATA_OUT, .DATA_OE, .SAR_RESULT,
    .SAR_CHANNEL, .CONTROL_WORD, .TRACK, .CORE_POWERED, .REF_POWERED, .POWER_UP_START);
  adcpp_host i_adcpp_host (.SYS_CLK, .CONVERT_START_N, .CONVERSION_CLOCK_IN, .BUSY, .CS_N,
    .RD_N, .WR_N, .WORD_BYTE_SELECT, .DATA_IN, .DATA_OUT, .DATA_OE);
  always #20 SYS_CLK = ~SYS_CLK;
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // word write, permanent read through a conversion, word read
  task automatic t_word();
    i_adcpp_host.wr(1'b1, 12'h80c);
    chk("cw", 12'h80c, CONTROL_WORD);
    SAR_RESULT = 12'hb3c;
    SAR_CHANNEL = 2'h2;
    i_adcpp_host.conv(1'b1, 4, v);
    chk("early data", 12'hb3c, v);
    chk("track", 12'h001, {11'h0, TRACK});
    i_adcpp_host.rd(1'b1, 1'b0, v);
    chk("word", 12'hb3c, v);
    chk("oe", 12'h000, {11'h0, DATA_OE});
  endtask
  // two byte reads of the same result
  task automatic t_byte();
    i_adcpp_host.rd(1'b0, 1'b0, v);
    chk("low byte", 12'h03c, {4'h0, v[7:0]});
    i_adcpp_host.rd(1'b0, 1'b1, v);
    chk("high byte", 12'h02b, v);
  endtask
  // early strobe return cuts the conversion
  task automatic t_abort();
    i_adcpp_host.abort();
    chk("busy", 12'h001, {11'h0, BUSY});
    i_adcpp_host.step(6);
    chk("aborted", 12'h001, {10'h0, BUSY, TRACK});
  endtask
  // full shutdown at write, normal write wakes
  task automatic t_fullsd();
    i_adcpp_host.wr(1'b1, 12'h030);
    chk("sd", 12'h000, {10'h0, CORE_POWERED, TRACK});
    i_adcpp_host.wr(1'b1, 12'h000);
    chk("awake", 12'h001, {11'h0, CORE_POWERED});
  endtask
  // byte writes select autoshutdown; down after end, rise wakes
  task automatic t_autosd();
    i_adcpp_host.wr(1'b0, 12'h01c);
    i_adcpp_host.wr(1'b0, 12'h104);
    chk("cw bytes", 12'h41c, CONTROL_WORD);
    i_adcpp_host.conv(1'b0, 4, v);
    chk("down", 12'h000, {10'h0, CORE_POWERED, TRACK});
    i_adcpp_host.rise();
    n = 0;
    repeat (8) begin
      i_adcpp_host.step(1);
      n += POWER_UP_START;
    end
    chk("wake", 12'h003, {10'h0, n == 1, TRACK});
    SAR_RESULT = 12'h2d1;
    i_adcpp_host.conv(1'b0, WAKE_CYC, v);
    i_adcpp_host.rd(1'b1, 1'b0, v);
    chk("sd result", 12'h2d1, v);
  endtask
  // autostandby keeps the reference up
  task automatic t_stby();
    i_adcpp_host.wr(1'b1, 12'h020);
    i_adcpp_host.conv(1'b0, 16, v);
    chk("stby", 12'h001, {10'h0, CORE_POWERED, REF_POWERED});
  endtask
  initial begin
    {SYS_CLK, RST_B, error_cnt, compares} = '0;
    SAR_RESULT = 12'h000;
    SAR_CHANNEL = 2'h0;
    repeat (16) @(posedge SYS_CLK);
    chk("rst", 12'h002, {10'h0, CORE_POWERED, TRACK});
    #1 RST_B = 1'b1;
    i_adcpp_host.step(6);
    chk("hold", 12'h000, {11'h0, TRACK});
    t_word();
    t_byte();
    t_abort();
    t_fullsd();
    t_autosd();
    t_stby();
    error_cnt += i_adcpp_host.tmo_cnt;
    end_sim();
  end
  // watchdog well beyond the few hundred cycles needed
  initial begin
    #800000;
    error_cnt++;
    end_sim();
  end
endmodule // tb
`default_nettype wire

// file: src/adcpp_defs.vh
`ifndef ADCPP_DEFS_VH
`define ADCPP_DEFS_VH

// ****************************************
// data path widths and byte layout
// ****************************************
`define ADCPP_DW        12        // full data word width
`define ADCPP_BW        8         // byte-mode lane width
`define ADCPP_HBS_BIT   8         // data line 8 doubles as high-byte select
`define ADCPP_CHW       2         // channel identifier width
`define ADCPP_CTL_RST   12'h000   // control word after power-on (normal mode)

// ****************************************
// power-management field
// ****************************************
`define ADCPP_PM_LO     4         // lower power bit position
`define ADCPP_PM_HI     5         // upper power bit position
`define ADCPP_PM_NORM   2'h0      // fully powered
`define ADCPP_PM_AUTOSD 2'h1      // shut down after each conversion
`define ADCPP_PM_STBY   2'h2      // all but reference down after conversion
`define ADCPP_PM_FULLSD 2'h3      // shut down at write strobe rising edge

// ****************************************
// conversion timing in conversion-clock edges, priming in sys cycles
// ****************************************
`define ADCPP_ABORT_FALLS 14      // strobe may rise only after this falling edge
`define ADCPP_TRACK_RISES 13      // sample-and-hold back to track on this rise
`define ADCPP_END_FALLS   14      // conversion ends on this falling edge
`define ADCPP_CNTW        5       // edge counter width
`define ADCPP_PRIME       3       // cycles until synchronised pins and edge copies are real

`endif

// file: src/adcpp_port.v
`include "adcpp_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module adcpp_port #(
  parameter DW = `ADCPP_DW            // data port width
) (
  // system clock and reset
  input  wire          SYS_CLK,
  input  wire          RST_B,
  // conversion control pins
  input  wire          CONVERT_START_N,
  input  wire          CONVERSION_CLOCK_IN,
  output wire          BUSY,
  // parallel bus pins
  input  wire          CS_N,
  input  wire          RD_N,
  input  wire          WR_N,
  input  wire          WORD_BYTE_SELECT,
  input  wire [DW-1:0] DATA_IN,
  output wire [DW-1:0] DATA_OUT,
  output wire          DATA_OE,
  // converter core side
  input  wire [DW-1:0] SAR_RESULT,
  input  wire [1:0]    SAR_CHANNEL,
  // state towards analog core
  output wire [DW-1:0] CONTROL_WORD,
  output wire          TRACK,
  output wire          CORE_POWERED,
  output wire          REF_POWERED,
  output wire          POWER_UP_START
);

  // ****************************************
  // pin synchronisation
  // ****************************************
  localparam SW = DW + 6;             // six control pins plus data

  wire [SW-1:0] pins_s;               // synchronised pin bundle
  wire          cvs_n_s;              // convert_start_n
  wire          cclk_s;               // conversion clock
  wire          cs_n_s;               // chip select
  wire          rd_n_s;               // read strobe
  wire          wr_n_s;               // write strobe
  wire          wb_s;                 // word/byte select
  wire [DW-1:0] din_s;                // data lines

  adcpp_sync #(
    .W        (SW)
  ) u_sync (
    .clk      (SYS_CLK),
    .rst_b    (RST_B),
    .async_in ({CONVERT_START_N, CONVERSION_CLOCK_IN, CS_N, RD_N, WR_N,
                WORD_BYTE_SELECT, DATA_IN}),
    .sync_out (pins_s)
  );

  assign {cvs_n_s, cclk_s, cs_n_s, rd_n_s, wr_n_s, wb_s, din_s} = pins_s;

  // ****************************************
  // edge detection on synchronised pins
  // ****************************************
  reg cvs_n_d_r;                      // previous convert strobe
  reg cclk_d_r;                       // previous conversion clock
  reg wr_act_d_r;                     // previous gated write active
  reg [`ADCPP_PRIME-1:0] prime_r;     // fills with ones after reset
  wire primed = prime_r[`ADCPP_PRIME-1]; // sync flops and copies hold pin values

  // edges masked until the synchroniser carries real pin levels, else the
  // all-zero reset of the flops reads as a strobe fall and a write
  wire wr_act   = primed & ~cs_n_s & ~wr_n_s; // select and write gated together
  wire cvs_fall = primed & cvs_n_d_r & ~cvs_n_s;
  wire cvs_rise = primed & ~cvs_n_d_r & cvs_n_s;
  wire cclk_rise = primed & ~cclk_d_r & cclk_s;
  wire cclk_fall = primed & cclk_d_r & ~cclk_s;
  wire wr_rise  = wr_act_d_r & ~wr_act; // end of write cycle

  // delayed copies; strobe idles high after reset
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cvs_n_d_r  <= 1'b1;
      cclk_d_r   <= 1'b0;
      wr_act_d_r <= 1'b0;
      prime_r    <= {`ADCPP_PRIME{1'b0}};
    end else begin
      prime_r    <= {prime_r[`ADCPP_PRIME-2:0], 1'b1};
      cvs_n_d_r  <= cvs_n_s;
      cclk_d_r   <= cclk_s;
      wr_act_d_r <= wr_act;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  reg  [DW-1:0] ctl_r;                // control word
  reg  [DW-1:0] ctl_nxt;
  wire          hbs = din_s[`ADCPP_HBS_BIT]; // high-byte select in byte mode

  // write merge; data lines sampled in the same sys cycle as the gated rise,
  // both through one synchroniser, so host hold time need not cover its delay
  always @* begin
    ctl_nxt = ctl_r;
    if (wr_rise) begin
      if (wb_s) begin
        ctl_nxt = din_s;
      end else if (!hbs) begin
        ctl_nxt[`ADCPP_BW-1:0] = din_s[`ADCPP_BW-1:0];
      end else begin
        ctl_nxt[DW-1:`ADCPP_BW] = din_s[DW-`ADCPP_BW-1:0];
      end
    end
  end

  // power-on value selects normal mode
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_r <= `ADCPP_CTL_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  wire [1:0] pm_nxt = {ctl_nxt[`ADCPP_PM_HI], ctl_nxt[`ADCPP_PM_LO]};

  // ****************************************
  // conversion sequencer
  // ****************************************
  localparam C_IDLE = 1'b0;           // waiting for strobe fall
  localparam C_CONV = 1'b1;           // converting

  reg                  cst_r;         // conversion state
  reg [`ADCPP_CNTW-1:0] rises_r;      // conversion-clock rises seen
  reg [`ADCPP_CNTW-1:0] falls_r;      // conversion-clock falls seen
  reg                  busy_r;        // busy pin
  reg                  track_r;       // sample-and-hold tracking
  reg [DW-1:0]         res_r;         // latched result
  reg [1:0]            chan_r;        // latched channel id
  reg                  done_r;        // one-cycle end pulse, result to bus
  reg                  done_d_r;      // busy falls here, after data is shown
  reg [1:0]            pwr_r;         // power state
  reg                  pup_r;         // power-up start pulse

  localparam P_ON   = 2'h0;           // fully powered
  localparam P_SD   = 2'h1;           // all circuitry down
  localparam P_STBY = 2'h2;           // reference only
  localparam P_FSD  = 2'h3;           // full shutdown by register

  // count edges since start; a fall counter hitting the end value
  // finishes the conversion, only conversion-clock edges time it
  wire end_hit   = (cst_r == C_CONV) & cclk_fall &
                   (falls_r == `ADCPP_END_FALLS - 1);
  wire early_rise = (cst_r == C_CONV) & cvs_rise &
                    (falls_r < `ADCPP_ABORT_FALLS);
  wire start     = (cst_r == C_IDLE) & cvs_fall & (pwr_r == P_ON);

  // conversion state machine and counters
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cst_r   <= C_IDLE;
      rises_r <= {`ADCPP_CNTW{1'b0}};
      falls_r <= {`ADCPP_CNTW{1'b0}};
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      done_r   <= 1'b0;
      done_d_r <= done_r;
      // busy drops a cycle after the bus data took the new result
      if (done_d_r) begin
        busy_r <= 1'b0;
      end
      case (cst_r)
        C_IDLE: begin
          if (start) begin
            cst_r   <= C_CONV;
            busy_r  <= 1'b1;
            rises_r <= {`ADCPP_CNTW{1'b0}};
            falls_r <= {`ADCPP_CNTW{1'b0}};
          end
        end
        C_CONV: begin
          if (early_rise) begin        // abort, busy drops at once
            cst_r  <= C_IDLE;
            busy_r <= 1'b0;
          end else if (end_hit) begin
            cst_r  <= C_IDLE;
            done_r <= 1'b1;            // result loads now, busy two cycles later
          end else begin
            if (cclk_rise) begin
              rises_r <= rises_r + 1'b1;
            end
            if (cclk_fall) begin
              falls_r <= falls_r + 1'b1;
            end
          end
        end
        default: begin
          cst_r <= C_IDLE;
        end
      endcase
    end
  end

  // result latch; loaded two cycles ahead of busy falling
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      res_r  <= {DW{1'b0}};
      chan_r <= 2'h0;
    end else if (end_hit) begin
      res_r  <= SAR_RESULT;
      chan_r <= SAR_CHANNEL;
    end
  end

  // ****************************************
  // sample-and-hold and power states
  // ****************************************
  wire track_rise = (cst_r == C_CONV) & cclk_rise &
                    (rises_r == `ADCPP_TRACK_RISES - 1);

  // track/hold and power manager; hold after power-on until first rise
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      track_r <= 1'b0;
      pwr_r   <= P_ON;
      pup_r   <= 1'b0;
    end else begin
      pup_r <= 1'b0;
      case (pwr_r)
        P_ON: begin
          if (start) begin
            track_r <= 1'b0;
          end else if (early_rise | track_rise) begin
            track_r <= 1'b1;
          end else if (cvs_rise && cst_r == C_IDLE) begin
            track_r <= 1'b1;
          end
          if (end_hit && pm_nxt == `ADCPP_PM_AUTOSD) begin
            pwr_r   <= P_SD;
            track_r <= 1'b0;
          end else if (end_hit && pm_nxt == `ADCPP_PM_STBY) begin
            pwr_r   <= P_STBY;
            track_r <= 1'b0;
          end
        end
        P_SD, P_STBY: begin
          if (cvs_rise) begin          // wake and track
            pwr_r   <= P_ON;
            track_r <= 1'b1;
            pup_r   <= 1'b1;
          end
        end
        P_FSD: begin
          if (wr_rise && pm_nxt != `ADCPP_PM_FULLSD) begin
            pwr_r   <= P_ON;
            track_r <= 1'b1;
            pup_r   <= 1'b1;
          end
        end
        default: begin
          pwr_r <= P_ON;
        end
      endcase
      // full shutdown wins, also mid conversion
      if (wr_rise && pm_nxt == `ADCPP_PM_FULLSD) begin
        pwr_r   <= P_FSD;
        track_r <= 1'b0;
        pup_r   <= 1'b0;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  reg  [DW-1:0] dout_r;               // registered bus data
  wire          rd_act = primed & ~cs_n_s & ~rd_n_s; // gated, level active

  // present word or selected byte every cycle; with permanent read
  // the new result follows res_r before busy falls
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dout_r <= {DW{1'b0}};
    end else if (wb_s) begin
      dout_r <= res_r;
    end else if (hbs) begin
      dout_r <= {{(DW-`ADCPP_BW){1'b0}}, 2'b00, chan_r,
                 res_r[DW-1:`ADCPP_BW]};
    end else begin
      dout_r <= {{(DW-`ADCPP_BW){1'b0}}, res_r[`ADCPP_BW-1:0]};
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign DATA_OUT       = dout_r;
  assign DATA_OE        = rd_act;
  assign BUSY           = busy_r;
  assign CONTROL_WORD   = ctl_r;
  assign TRACK          = track_r;
  assign CORE_POWERED   = (pwr_r == P_ON);
  assign REF_POWERED    = (pwr_r == P_ON) | (pwr_r == P_STBY);
  assign POWER_UP_START = pup_r;

endmodule // adcpp_port

`default_nettype wire

// file: src/adcpp_sync.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// two-flop synchroniser for pin inputs
// ****************************************
module adcpp_sync #(
  parameter W = 1                     // number of bits
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // async in, sync out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;                 // first stage, read only by second
  reg [W-1:0] sync_r;                 // second stage

  // plain double flop; reset value all zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // adcpp_sync

`default_nettype wire
